// file: hw/mcu_address_map_decoder.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module mcu_address_map_decoder #(
    parameter int ROM_BYTES = 32768,
    parameter int RAM_BYTES = 2560,
    parameter int TC_BLOCKS = 22
) (
    input  wire logic                           clk_sys_in,
    input  wire logic                           reset_n_in,
    input  wire logic [mcu_map_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                           avs_read_in,
    input  wire logic                           avs_write_in,
    input  wire logic [mcu_map_pkg::DATA_W-1:0] avs_writedata_in,
    output logic      [mcu_map_pkg::DATA_W-1:0] avs_readdata_out,
    output logic                                avs_waitrequest_out,
    output mcu_map_pkg::mem_req_s               mem_req_out,
    input  wire logic [mcu_map_pkg::DATA_W-1:0] mem_rdata_in,
    output logic                                iface_view_select_out
);
    import mcu_map_pkg::*;

    // Derived region limits and transfer controller storage size.
    localparam logic [19:0] RAM_LAST  = ADDR_W'(RAM_FIRST + RAM_BYTES - 1);
    localparam logic [19:0] ROM_FIRST = ADDR_W'(ROM_END + 1 - ROM_BYTES);
    localparam int          TC_BYTES  =
        TC_VECTOR_BYTES + TC_BLOCK_BYTES * TC_BLOCKS;
    localparam logic [19:0] TC_LAST   = ADDR_W'(TC_FIRST + TC_BYTES - 1);
    localparam int          TC_IDX_W  = $clog2(TC_BYTES);

    typedef struct packed {
        bus_state_e                        state;
        logic                              is_write;
        logic [DATA_W-1:0]                 rdata;
        mem_req_s                          mem;
        sfr_bank_t                         sfr;
        logic [TC_BYTES-1:0][DATA_W-1:0]   tc;
    } state_s;

    // Builds the register bank image that reset loads.
    function automatic sfr_bank_t reset_image();
        sfr_bank_t img;
        img = '0;
        for (int i = 0; i < SFR_COUNT; i++) begin
            img[i] = SFR_TABLE[i].rst;
        end
        return img;
    endfunction : reset_image

    localparam sfr_bank_t SFR_RESET_IMAGE = reset_image();

    // Sorts a core address into exactly one region.
    function automatic region_e region_of(input logic [19:0] a);
        region_e r;
        r = REGION_NONE;
        if (a <= SFR_LOW_LAST) begin
            r = REGION_SFR;
        end else if (a >= RAM_FIRST && a <= RAM_LAST) begin
            r = REGION_RAM;
        end else if (a >= FLASH_FIRST && a <= FLASH_LAST) begin
            r = REGION_FLASH;
        end else if (a >= SFR_HIGH_FIRST && a <= SFR_HIGH_LAST) begin
            r = REGION_SFR;
        end else if (a >= VECTOR_FIRST && a <= ROM_END) begin
            r = REGION_VECTOR;
        end else if (a >= ROM_FIRST && a <= ROM_END) begin
            r = REGION_ROM;
        end
        return r;
    endfunction : region_of

    // Finds a register for an address; bit 7 flags a hit.
    function automatic logic [7:0] sfr_find(input logic [19:0] a,
                                            input logic wire_view);
        logic [7:0] res;
        view_e      want;
        res  = 8'h00;
        want = wire_view ? VIEW_WIRE : VIEW_SYNC;
        for (int i = 0; i < SFR_COUNT; i++) begin
            if (a[19:12] == 8'h00 && SFR_TABLE[i].addr == a[11:0] &&
                (SFR_TABLE[i].view == VIEW_ALL ||
                 SFR_TABLE[i].view == want)) begin
                res = {1'b1, 7'(i)};
            end
        end
        return res;
    endfunction : sfr_find

    // True when an address lies in transfer controller storage.
    function automatic logic tc_hit(input logic [19:0] a);
        return a >= TC_FIRST && a <= TC_LAST;
    endfunction : tc_hit

    // Bits of a register that software may change.
    function automatic logic [7:0] write_mask(input logic [19:0] a);
        logic [7:0] m;
        m = 8'hff;
        if (a[11:0] == ADDR_MATCH0_TOP || a[11:0] == ADDR_MATCH1_TOP) begin
            m = ADDR_MATCH_TOP_MASK;
        end
        return m;
    endfunction : write_mask

    // True for regions served by the memory port.
    function automatic logic is_memory(input region_e r);
        return r == REGION_ROM || r == REGION_VECTOR ||
               r == REGION_FLASH || r == REGION_RAM;
    endfunction : is_memory

    state_s            st;
    state_s            next_st;
    logic              request;
    logic              view_wire;
    logic [7:0]        found;
    logic [6:0]        found_idx;
    logic              found_hit;
    logic              in_tc;
    logic [TC_IDX_W-1:0] tc_off;

    // Lookups shared by the next-state logic and the checks.
    assign request   = avs_read_in | avs_write_in;
    assign view_wire = st.sfr[IDX_VIEW_SEL][VIEW_SEL_BIT];
    assign found     = sfr_find(st.mem.addr, view_wire);
    assign found_hit = found[7];
    assign found_idx = found[6:0];
    assign in_tc     = tc_hit(st.mem.addr);
    assign tc_off    = TC_IDX_W'(st.mem.addr - TC_FIRST);

    // Bus sequencing: latch, decode and read, then acknowledge.
    always_comb begin
        next_st = st;
        unique case (st.state)
            ST_IDLE: begin
                if (request) begin
                    next_st.mem.region = region_of(avs_address_in);
                    next_st.mem.addr   = avs_address_in;
                    next_st.mem.wdata  = avs_writedata_in;
                    next_st.mem.rd     = avs_read_in &&
                        is_memory(region_of(avs_address_in));
                    next_st.is_write   = avs_write_in;
                    next_st.state      = ST_DECODE;
                end
            end
            ST_DECODE: begin
                next_st.mem.rd = 1'b0;
                next_st.mem.wr = st.is_write &&
                                 st.mem.region == REGION_RAM;
                if (is_memory(st.mem.region)) begin
                    next_st.rdata = mem_rdata_in;
                end else if (st.mem.region == REGION_SFR && found_hit) begin
                    next_st.rdata = st.sfr[found_idx];
                end else if (st.mem.region == REGION_SFR && in_tc) begin
                    next_st.rdata = st.tc[tc_off];
                end else begin
                    next_st.rdata = RESERVED_READ;
                end
                next_st.state = ST_ACK;
            end
            ST_ACK: begin
                next_st.mem.wr = 1'b0;
                next_st.state  = ST_IDLE;
                if (st.is_write && st.mem.region == REGION_SFR) begin
                    if (found_hit) begin
                        next_st.sfr[found_idx] = st.mem.wdata &
                            write_mask(st.mem.addr);
                    end else if (in_tc) begin
                        next_st.tc[tc_off] = st.mem.wdata;
                    end
                    // Holes take no write at all.
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    // State register; undefined storage is cleared to zero.
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st.state    <= ST_IDLE;
            st.is_write <= 1'b0;
            st.rdata    <= '0;
            st.mem      <= '0;
            st.sfr      <= SFR_RESET_IMAGE;
            st.tc       <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Handshake is combinational, data comes from flip-flops.
    assign avs_waitrequest_out   = request && st.state != ST_ACK;
    assign avs_readdata_out      = st.rdata;
    assign mem_req_out           = st.mem;
    assign iface_view_select_out = view_wire;

    // Helper flag: high for the first cycle after reset release.
    logic after_reset;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            after_reset <= 1'b1;
        end else begin
            after_reset <= 1'b0;
        end
    end

    // A request in idle passes decode, then acknowledges.
    sequence s_decode_then_ack;
        st.state == ST_DECODE ##1
        (st.state == ST_ACK && !avs_waitrequest_out);
    endsequence

    sequence s_back_to_idle;
        st.state == ST_IDLE && !mem_req_out.wr;
    endsequence

    property p_request_flow;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_IDLE && request) |=>
            s_decode_then_ack ##1 s_back_to_idle;
    endproperty

    a_bus_request_flow: assert property (p_request_flow)
        else $error("Bus request did not finish in two wait cycles.");

    a_rom_route_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.addr >= ROM_FIRST &&
         st.mem.addr < VECTOR_FIRST) |-> st.mem.region == REGION_ROM)
        else $error("ROM address not routed to program ROM.");

    a_vector_route_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.addr >= VECTOR_FIRST &&
         st.mem.addr <= ROM_END) |-> st.mem.region == REGION_VECTOR)
        else $error("Vector address not routed to vector table.");

    a_flash_route_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.addr >= FLASH_FIRST &&
         st.mem.addr <= FLASH_LAST) |-> st.mem.region == REGION_FLASH)
        else $error("Flash address not routed to data flash.");

    a_ram_route_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.addr >= RAM_FIRST &&
         st.mem.addr <= RAM_LAST) |->
            st.mem.region == REGION_RAM ##1 mem_req_out.wr == st.is_write)
        else $error("RAM address or write strobe misrouted.");

    a_sfr_route_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && (st.mem.addr <= SFR_LOW_LAST ||
         (st.mem.addr >= SFR_HIGH_FIRST && st.mem.addr <= SFR_HIGH_LAST)))
            |-> st.mem.region == REGION_SFR && !mem_req_out.rd)
        else $error("Register address not routed to register space.");

    a_hole_write_dropped: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_ACK && st.mem.region != REGION_RAM) |=>
            !mem_req_out.wr && (found_hit || $stable(st.sfr)) &&
            (in_tc || $stable(st.tc)))
        else $error("Write to a reserved location changed state.");

    a_hole_read_zero: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.region == REGION_SFR &&
         !found_hit && !in_tc) |=> st.rdata == RESERVED_READ)
        else $error("Reserved register read returned stray data.");

    a_view_read_bank: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && st.mem.region == REGION_SFR &&
         found_hit) |=> st.rdata == $past(st.sfr[found_idx]))
        else $error("Register read did not return the selected view.");

    a_reset_image_ok: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        after_reset |-> st.sfr == SFR_RESET_IMAGE && st.tc == '0 &&
            st.state == ST_IDLE && !mem_req_out.rd && !mem_req_out.wr)
        else $error("Register bank left reset with wrong values.");

    a_addr_match_top: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        st.state == ST_ACK |=>
            st.sfr[65][7:4] == 4'h0 && st.sfr[69][7:4] == 4'h0)
        else $error("Address match top nibble became nonzero.");

    // A register hit belongs to the addressed byte and the chosen view.
    a_hit_in_view: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_DECODE && found_hit) |->
            SFR_TABLE[found_idx].addr == st.mem.addr[11:0] &&
            SFR_TABLE[found_idx].view != (view_wire ? VIEW_SYNC : VIEW_WIRE))
        else $error("Register hit outside the selected view.");

    // A write into transfer storage lands in the addressed byte.
    a_tc_write_lands: assert property (
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (st.state == ST_ACK && st.is_write && st.mem.region == REGION_SFR &&
         !found_hit && in_tc) |=> st.tc[tc_off] == st.mem.wdata)
        else $error("Transfer storage write did not land.");

endmodule : mcu_address_map_decoder

`default_nettype wire

// file: hw/mcu_map_pkg.sv
package mcu_map_pkg;

    // Bus and address space geometry.
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;

    // Region boundaries of the one-megabyte space.
    localparam logic [19:0] SPACE_LAST     = 20'hfffff;
    localparam logic [19:0] ROM_END        = 20'h0ffff;
    localparam logic [19:0] VECTOR_FIRST   = 20'h0ffdc;
    localparam logic [19:0] FLASH_FIRST    = 20'h03000;
    localparam logic [19:0] FLASH_LAST     = 20'h03fff;
    localparam logic [19:0] RAM_FIRST      = 20'h00400;
    localparam logic [19:0] SFR_LOW_LAST   = 20'h002ff;
    localparam logic [19:0] SFR_HIGH_FIRST = 20'h02c00;
    localparam logic [19:0] SFR_HIGH_LAST  = 20'h02fff;

    // Transfer controller vector area and control data blocks.
    localparam logic [19:0] TC_FIRST        = 20'h02c00;
    localparam int          TC_VECTOR_BYTES = 64;
    localparam int          TC_BLOCK_BYTES  = 8;

    // Special register details used by the decoder.
    localparam int          IDX_VIEW_SEL  = 37;
    localparam int          VIEW_SEL_BIT  = 0;
    localparam logic [11:0] ADDR_MATCH0_TOP = 12'h1c2;
    localparam logic [11:0] ADDR_MATCH1_TOP = 12'h1c6;
    localparam logic [7:0]  ADDR_MATCH_TOP_MASK = 8'h0f;
    localparam logic [7:0]  RESERVED_READ = 8'h00;

    typedef enum logic [2:0] {
        REGION_NONE   = 3'b000,
        REGION_ROM    = 3'b001,
        REGION_VECTOR = 3'b010,
        REGION_FLASH  = 3'b011,
        REGION_RAM    = 3'b100,
        REGION_SFR    = 3'b101
    } region_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DECODE = 2'b01,
        ST_ACK    = 2'b10
    } bus_state_e;

    typedef enum logic [1:0] {
        VIEW_ALL  = 2'b00,
        VIEW_SYNC = 2'b01,
        VIEW_WIRE = 2'b10
    } view_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  rst;
        view_e       view;
    } sfr_entry_s;

    typedef struct packed {
        region_e     region;
        logic [19:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } mem_req_s;

    // Register map: offset, reset value, serial view.
    localparam int SFR_COUNT = 71;
    typedef logic [SFR_COUNT-1:0][DATA_W-1:0] sfr_bank_t;
    localparam sfr_entry_s SFR_TABLE [SFR_COUNT] = '{
        '{12'h03a, 8'h82, VIEW_ALL}, '{12'h041, 8'h00, VIEW_ALL},
        '{12'h046, 8'h00, VIEW_ALL}, '{12'h047, 8'h00, VIEW_ALL},
        '{12'h048, 8'h00, VIEW_ALL}, '{12'h049, 8'h00, VIEW_ALL},
        '{12'h04a, 8'h00, VIEW_ALL}, '{12'h04b, 8'h00, VIEW_ALL},
        '{12'h04c, 8'h00, VIEW_ALL}, '{12'h04d, 8'h00, VIEW_ALL},
        '{12'h04e, 8'h00, VIEW_ALL}, '{12'h04f, 8'h00, VIEW_SYNC},
        '{12'h04f, 8'h00, VIEW_WIRE}, '{12'h051, 8'h00, VIEW_ALL},
        '{12'h052, 8'h00, VIEW_ALL}, '{12'h053, 8'h00, VIEW_ALL},
        '{12'h054, 8'h00, VIEW_ALL}, '{12'h055, 8'h00, VIEW_ALL},
        '{12'h056, 8'h00, VIEW_ALL}, '{12'h058, 8'h00, VIEW_ALL},
        '{12'h059, 8'h00, VIEW_ALL}, '{12'h05a, 8'h00, VIEW_ALL},
        '{12'h05d, 8'h00, VIEW_ALL}, '{12'h05e, 8'h00, VIEW_ALL},
        '{12'h072, 8'h00, VIEW_ALL}, '{12'h073, 8'h00, VIEW_ALL},
        '{12'h180, 8'h00, VIEW_ALL}, '{12'h181, 8'h00, VIEW_ALL},
        '{12'h182, 8'h00, VIEW_ALL}, '{12'h183, 8'h00, VIEW_ALL},
        '{12'h184, 8'h00, VIEW_ALL}, '{12'h185, 8'h00, VIEW_ALL},
        '{12'h186, 8'h00, VIEW_ALL}, '{12'h188, 8'h00, VIEW_ALL},
        '{12'h189, 8'h00, VIEW_ALL}, '{12'h18a, 8'h00, VIEW_ALL},
        '{12'h18b, 8'h00, VIEW_ALL}, '{12'h18c, 8'h00, VIEW_ALL},
        '{12'h18e, 8'h00, VIEW_ALL}, '{12'h18f, 8'h00, VIEW_ALL},
        '{12'h193, 8'hf8, VIEW_ALL}, '{12'h194, 8'hff, VIEW_SYNC},
        '{12'h194, 8'hff, VIEW_WIRE}, '{12'h195, 8'hff, VIEW_SYNC},
        '{12'h196, 8'hff, VIEW_SYNC}, '{12'h196, 8'hff, VIEW_WIRE},
        '{12'h197, 8'hff, VIEW_SYNC}, '{12'h198, 8'h00, VIEW_SYNC},
        '{12'h198, 8'h00, VIEW_WIRE}, '{12'h199, 8'h3d, VIEW_SYNC},
        '{12'h199, 8'h3d, VIEW_WIRE}, '{12'h19a, 8'h10, VIEW_SYNC},
        '{12'h19a, 8'h18, VIEW_WIRE}, '{12'h19b, 8'h00, VIEW_SYNC},
        '{12'h19b, 8'h00, VIEW_WIRE}, '{12'h19c, 8'h00, VIEW_SYNC},
        '{12'h19c, 8'h00, VIEW_WIRE}, '{12'h19d, 8'h00, VIEW_SYNC},
        '{12'h19d, 8'h00, VIEW_WIRE}, '{12'h1b2, 8'h80, VIEW_ALL},
        '{12'h1b4, 8'h00, VIEW_ALL}, '{12'h1b5, 8'h00, VIEW_ALL},
        '{12'h1b6, 8'h00, VIEW_ALL}, '{12'h1c0, 8'h00, VIEW_ALL},
        '{12'h1c1, 8'h00, VIEW_ALL}, '{12'h1c2, 8'h00, VIEW_ALL},
        '{12'h1c3, 8'h00, VIEW_ALL}, '{12'h1c4, 8'h00, VIEW_ALL},
        '{12'h1c5, 8'h00, VIEW_ALL}, '{12'h1c6, 8'h00, VIEW_ALL},
        '{12'h1c7, 8'h00, VIEW_ALL}
    };

endpackage : mcu_map_pkg

// file: verif/mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_model (
    input  wire logic                           clk_sys_in,
    input  wire mcu_map_pkg::mem_req_s          mem_req_in,
    output logic      [mcu_map_pkg::DATA_W-1:0] mem_rdata_out
);
    import mcu_map_pkg::*;

    logic [7:0] ram [4096];
    logic [7:0] last;
    logic [7:0] value;

    // RAM starts with the address pattern that ROM and flash always show.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'(i) ^ {4'h0, 4'(i >> 8)} ^ 8'h5a;
        end
        last = 8'h00;
    end

    // Data is driven only while rd is high; a released line shows the
    // inverse of its last value so a late sample cannot pass by chance.
    always_comb begin
        if (mem_req_in.region == REGION_RAM) begin
            value = ram[mem_req_in.addr[11:0]];
        end else begin
            value = mem_req_in.addr[7:0] ^ mem_req_in.addr[15:8] ^ 8'h5a;
        end
        mem_rdata_out = mem_req_in.rd ? value : ~last;
    end

    // RAM stores writes; ROM, vector and flash contents never change.
    always @(posedge clk_sys_in) begin
        if (mem_req_in.rd) last <= value;
        if (mem_req_in.wr && mem_req_in.region == REGION_RAM)
            ram[mem_req_in.addr[11:0]] <= mem_req_in.wdata;
    end
endmodule : mem_model

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import mcu_map_pkg::*;

    localparam int ROM_BYTES = 32768;
    localparam int RAM_BYTES = 2560;
    localparam int TC_BLOCKS = 22;
    localparam int TIMEOUT_CYCLES = 20000;

    logic        clk_sys_in;
    logic        reset_n_in;
    logic [19:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [7:0]  avs_writedata;
    logic [7:0]  avs_readdata;
    logic        avs_waitrequest;
    mem_req_s    mem_req;
    mem_req_s    req_c1;
    mem_req_s    req_c2;
    logic [7:0]  mem_rdata;
    logic        view_sel;
    logic [7:0]  shadow [int];
    logic [7:0]  q;
    logic [7:0]  d;
    logic [19:0] a;
    logic [15:0] r;
    int          fail_count;
    int          n_compared;
    int          cycles;
    logic [19:0] corners [18] = '{20'h00300, 20'h003ff, 20'h00400,
        20'h00dff, 20'h00e00, 20'h02bff, 20'h03000, 20'h03fff, 20'h04000,
        20'h07fff, 20'h08000, 20'h0ffdb, 20'h0ffdc, 20'h0ffff, 20'h10000,
        20'hfffff, 20'h0003a, 20'h02c00};

    mcu_address_map_decoder #(.ROM_BYTES(ROM_BYTES), .RAM_BYTES(RAM_BYTES),
        .TC_BLOCKS(TC_BLOCKS)) mcu_address_map_decoder_inst (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .mem_req_out(mem_req),
        .mem_rdata_in(mem_rdata), .iface_view_select_out(view_sel));

    mem_model mem_model_inst (.clk_sys_in(clk_sys_in),
        .mem_req_in(mem_req), .mem_rdata_out(mem_rdata));

    // Free-running 10 MHz clock.
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // A hang is cut short and reported as a mismatch.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [19:0] seen,
                         input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon transfer; waitrequest and readdata are taken at the
    // rising edge, before the register updates of that edge land.
    task automatic bus_xfer(input logic is_wr, input logic [19:0] addr,
                            input logic [7:0] wdata, output logic [7:0] rdata);
        int   n;
        logic w;
        n = 0;
        rdata = 8'h00;
        @(posedge clk_sys_in);
        avs_address   <= addr;
        avs_writedata <= wdata;
        avs_read      <= !is_wr;
        avs_write     <= is_wr;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (n == 2) req_c1 = mem_req;
            if (n == 3) req_c2 = mem_req;
            w = avs_waitrequest;
            if (w === 1'b0) rdata = avs_readdata;
        end while (w !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_xfer

    task automatic rd_check(input logic [19:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        bus_xfer(1'b0, addr, 8'h00, v);
        check("register read", 20'(v), 20'(exp));
    endtask : rd_check

    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
    endtask : do_reset

    // Returns {mask, value} of the reset state; a zero mask skips the byte.
    function automatic logic [15:0] rst_exp(input logic [11:0] ad);
        case (ad) inside
            12'h03a: return {8'hff, 8'h82};
            12'h046, 12'h055, 12'h059, 12'h05a, 12'h05d:
                return {8'h37, 8'h00};
            12'h041, [12'h047:12'h04f], [12'h051:12'h054], 12'h056, 12'h058,
            12'h05e, 12'h072, 12'h073: return {8'h07, 8'h00};
            [12'h180:12'h18f]: return {8'hff, 8'h00};
            12'h193: return {8'hff, 8'hf8};
            [12'h194:12'h197]: return {8'hff, 8'hff};
            12'h19a: return {8'hff, 8'h10};
            12'h1b2: return {8'hfb, 8'h80};
            12'h1c2, 12'h1c6: return {8'hf0, 8'h00};
            [12'h03b:12'h040], [12'h042:12'h045], 12'h050, 12'h057,
            12'h05b, 12'h05c, [12'h05f:12'h071], [12'h074:12'h07f],
            [12'h190:12'h192], [12'h19e:12'h1b1], 12'h1b3,
            [12'h1b7:12'h1bf], [12'h1c8:12'h1df]:
                return {8'hff, 8'h00};
            default: return 16'h0000;
        endcase
    endfunction : rst_exp

    function automatic region_e exp_region(input logic [19:0] ad);
        if (ad <= SFR_LOW_LAST) return REGION_SFR;
        if (ad < RAM_FIRST) return REGION_NONE;
        if (ad < RAM_FIRST + RAM_BYTES) return REGION_RAM;
        if (ad >= FLASH_FIRST && ad <= FLASH_LAST)
            return REGION_FLASH;
        if (ad >= SFR_HIGH_FIRST && ad <= SFR_HIGH_LAST)
            return REGION_SFR;
        if (ad >= VECTOR_FIRST && ad <= ROM_END)
            return REGION_VECTOR;
        if (ad > ROM_END - ROM_BYTES && ad <= ROM_END)
            return REGION_ROM;
        return REGION_NONE;
    endfunction : exp_region

    // Reads one address and checks decode, strobe and returned byte.
    task automatic mem_check(input logic [19:0] ad);
        logic [7:0] v;
        region_e    e;
        logic [7:0] x;
        e = exp_region(ad);
        x = ad[7:0] ^ ad[15:8] ^ 8'h5a;
        if (e == REGION_RAM && shadow.exists(int'(ad))) x = shadow[int'(ad)];
        bus_xfer(1'b0, ad, 8'h00, v);
        check("region", 20'(req_c1.region), 20'(e));
        check("read strobe", 20'(req_c1.rd), 20'(e != REGION_NONE &&
              e != REGION_SFR));
        if (e == REGION_NONE) check("hole data", 20'(v), 20'h0);
        if (e != REGION_NONE && e != REGION_SFR) begin
            check("address", req_c1.addr, ad);
            check("memory data", 20'(v), 20'(x));
        end
    endtask : mem_check

    // Main sequence: reset map, serial views, holes, decode, reset again.
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        reset_n_in = 1'b0;
        void'($urandom(41929));
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (int i = 12'h03a; i < 12'h1e0; i++) begin
            r = rst_exp(12'(i));
            if (r[15:8] != 8'h00) begin
                bus_xfer(1'b0, 20'(i), 8'h00, q);
                check("reset value", 20'(q & r[15:8]), 20'(r[7:0]));
            end
        end
        check("view select", 20'(view_sel), 20'h0);
        bus_xfer(1'b1, 20'h0018c, 8'h01, q);
        // The write lands at the acknowledging edge; look one edge later.
        @(posedge clk_sys_in);
        check("view select", 20'(view_sel), 20'h1);
        rd_check(20'h0019a, 8'h18);
        rd_check(20'h00195, 8'h00);
        bus_xfer(1'b1, 20'h0004f, 8'h05, q);
        bus_xfer(1'b1, 20'h0018c, 8'h00, q);
        rd_check(20'h0004f, 8'h00);
        rd_check(20'h0019a, 8'h10);
        bus_xfer(1'b1, 20'h0018c, 8'h01, q);
        rd_check(20'h0004f, 8'h05);
        bus_xfer(1'b1, 20'h00050, 8'ha5, q);
        rd_check(20'h00050, 8'h00);
        bus_xfer(1'b1, 20'h001c2, 8'hff, q);
        rd_check(20'h001c2, 8'h0f);
        bus_xfer(1'b1, 20'h02cf0, 8'h3c, q);
        rd_check(20'h02cf0, 8'h00);
        foreach (corners[k]) mem_check(corners[k]);
        for (int i = 0; i < 20; i++) begin
            d = 8'($urandom());
            a = (i == 0) ? 20'h02c3f : (i == 1) ? 20'h02cef : 20'h00180;
            bus_xfer(1'b1, a, d, q);
            rd_check(a, d);
            a = 20'(RAM_FIRST + ($urandom() % RAM_BYTES));
            bus_xfer(1'b1, a, d, q);
            check("write strobe", 20'(req_c2.wr), 20'h1);
            shadow[int'(a)] = d;
            mem_check(a);
        end
        bus_xfer(1'b1, 20'h08000, 8'h77, q);
        check("write strobe", 20'(req_c2.wr), 20'h0);
        for (int i = 0; i < 150; i++) begin
            a = 20'($urandom());
            if (i % 2 == 0) a = a & 20'h0ffff;
            if (exp_region(a) != REGION_SFR) mem_check(a);
        end
        do_reset();
        check("view select", 20'(view_sel), 20'h0);
        rd_check(20'h00180, 8'h00);
        rd_check(20'h0019a, 8'h10);
        close_out();
    end
endmodule : testbench

`default_nettype wire
